// >>> apf_pkg.sv
// Shared constants, types and checksum helper for the attitude packet framer
`default_nettype none
package apf_pkg;

    // ****************************************************************
    // Framing
    // ****************************************************************
    localparam logic [7:0] HDR0 = 8'hAA;
    localparam logic [7:0] HDR1 = 8'h55;
    localparam int PKT_BYTES = 26;
    localparam logic [4:0] IDX_PAY_FIRST = 5'h02;
    localparam logic [4:0] IDX_PAY_LAST = 5'h17;
    localparam logic [4:0] IDX_CK_HI = 5'h18;
    localparam logic [4:0] IDX_CK_LO = 5'h19;
    localparam logic [4:0] IDX_HEADING_HI = 5'h06;
    localparam logic [4:0] IDX_MODEL_HI = 5'h14;
    localparam logic [16:0] CSUM_MOD = 17'h0FFFF;
    localparam int VEL_BYTES = 8;
    localparam logic [7:0] VEL_LAST = 8'h07;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int TX_BAUD = 38400;
    localparam int VEL_BAUD = 9600;
    localparam logic [15:0] TX_DIV = 16'(CLK_HZ / TX_BAUD);
    localparam logic [15:0] VEL_DIV = 16'(CLK_HZ / VEL_BAUD);
    localparam logic [15:0] VEL_HALF = 16'(CLK_HZ / VEL_BAUD / 2);
    localparam logic [3:0] STOP_BIT = 4'h9;
    localparam int RATE0_HZ = 100;
    localparam int RATE1_HZ = 50;
    localparam int RATE2_HZ = 25;
    localparam int RATE3_HZ = 10;
    localparam int VEL_TIMEOUT_MS = 2000;
    localparam int VEL_TIMEOUT_CYC = CLK_HZ / 1000 * VEL_TIMEOUT_MS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] roll;
        logic [15:0] pitch;
        logic [15:0] heading;
        logic [15:0] rollRate;
        logic [15:0] pitchRate;
        logic [15:0] yawRate;
        logic [15:0] accX;
        logic [15:0] accY;
        logic [15:0] accZ;
    } apf_meas_t;

    typedef struct packed {
        apf_meas_t meas;
        logic [15:0] model;
        logic [15:0] bitWord;
    } apf_frame_t;

    typedef enum logic {CY_SAMPLE, CY_PROCESS} apf_cyc_t;
    typedef enum logic [2:0] {PS_HDR0, PS_HDR1, PS_BODY, PS_CK0, PS_CK1} apf_parse_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} apf_rxst_t;

    typedef struct packed {
        apf_rxst_t fsm;
        logic [15:0] div;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [7:0] data;
        logic valid;
        logic err;
    } apf_rx_t;

    // Remainder of a running byte sum divided by FFFF
    function automatic logic [15:0] csumAdd(input logic [15:0] acc, input logic [7:0] b);
        logic [16:0] s;
        s = {1'b0, acc} + {9'h000, b};
        if (s >= CSUM_MOD) begin
            s = s - CSUM_MOD;
        end
        return s[15:0];
    endfunction

endpackage
`default_nettype wire

// >>> apf_uart_rx.sv
// Byte receiver for the velocity input line, 8N1, sampling mid-bit
`default_nettype none
module apf_uart_rx #(
    parameter int BIT_CYC = int'(apf_pkg::VEL_DIV)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rxd,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxErr
);
    apf_pkg::apf_rx_t st;
    apf_pkg::apf_rx_t next_st;

    always_comb begin
        next_st = st;
        next_st.valid = 1'b0;
        next_st.err = 1'b0;
        next_st.div = st.div + 16'h0001;
        case (st.fsm)
            apf_pkg::RX_IDLE: begin
                next_st.div = 16'h0000;
                if (!rxd) begin
                    next_st.fsm = apf_pkg::RX_START;
                end
            end
            apf_pkg::RX_START: begin
                // A glitch shorter than half a bit is not a start bit
                if (st.div == 16'(BIT_CYC / 2)) begin
                    next_st.div = 16'h0000;
                    next_st.cnt = 3'h0;
                    next_st.fsm = rxd ? apf_pkg::RX_IDLE : apf_pkg::RX_DATA;
                end
            end
            apf_pkg::RX_DATA: begin
                if (st.div == 16'(BIT_CYC - 1)) begin
                    next_st.div = 16'h0000;
                    next_st.shift = {rxd, st.shift[7:1]};
                    next_st.cnt = st.cnt + 3'h1;
                    if (st.cnt == 3'h7) begin
                        next_st.fsm = apf_pkg::RX_STOP;
                    end
                end
            end
            apf_pkg::RX_STOP: begin
                if (st.div == 16'(BIT_CYC - 1)) begin
                    next_st.fsm = apf_pkg::RX_IDLE;
                    next_st.data = st.shift;
                    next_st.valid = rxd;
                    next_st.err = !rxd;
                end
            end
            default: begin
                next_st.fsm = apf_pkg::RX_IDLE;
            end
        endcase
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign rxData = st.data;
    assign rxValid = st.valid;
    assign rxErr = st.err;

endmodule
`default_nettype wire

// >>> apf_framer.sv
// Measurement packet framer, serial transmitter and velocity packet receiver
`default_nettype none
// Functional notes
// (RQ1) Every packet, sent or received, starts with header bytes AA then 55.
// (RQ2) Every packet ends with a two-byte checksum after the payload.
// (RQ3) Checksum is payload byte sum modulo FFFF, header and checksum excluded.
// (RQ4) Outgoing packet carries model configuration number and built-in-test word.
// (RQ5) Packets leave at a constant rate fixed by model configuration.
// (RQ6) Device loops forever: sample sensors, process, sample again.
// (RQ7) Next sampling starts as soon as a result is ready for sending.
// (RQ8) Processed packet is sent on the serial port as third stage.
// (RQ9) Heading goes out magnetic-referenced, no declination correction.
// (RQ10) Receive velocity packets, detect valid ones, pass their fields on.
// (RQ11) Fall back to unaided computation when velocity is absent or lost.
// (RQ12) Each field is 16-bit two's complement, high byte first.
// (RQ13) Serial output is 8 data bits, one start, one stop, no parity.
// (RQ14) Velocity source sends at 9600 baud 8N1, once per second.
// (RQ15) Velocity packets with bad header or checksum are discarded as invalid.
module apf_framer #(
    parameter int PERIOD0_CYC = apf_pkg::CLK_HZ / apf_pkg::RATE0_HZ,
    parameter int PERIOD1_CYC = apf_pkg::CLK_HZ / apf_pkg::RATE1_HZ,
    parameter int PERIOD2_CYC = apf_pkg::CLK_HZ / apf_pkg::RATE2_HZ,
    parameter int PERIOD3_CYC = apf_pkg::CLK_HZ / apf_pkg::RATE3_HZ,
    parameter int VEL_TIMEOUT_CYC = apf_pkg::VEL_TIMEOUT_CYC,
    parameter int TX_BIT_CYC = int'(apf_pkg::TX_DIV),
    parameter int VEL_BIT_CYC = int'(apf_pkg::VEL_DIV)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] modelCfg,
    input wire logic [15:0] modelNum,
    input wire logic [15:0] bitWord,
    output logic sampleReq,
    input wire logic procDone,
    input wire apf_pkg::apf_meas_t procData,
    output logic txd,
    input wire logic rxd,
    output logic [apf_pkg::VEL_BYTES*8-1:0] velData,
    output logic velStrobe,
    output logic velAided
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic cfgTaken;
        logic [31:0] period;
        logic [31:0] tickCnt;
        apf_pkg::apf_cyc_t cyc;
        logic sampleReq;
        apf_pkg::apf_frame_t hold;
        logic holdValid;
        apf_pkg::apf_frame_t txFrame;
        logic txBusy;
        logic txLine;
        logic [9:0] txShift;
        logic [3:0] txBitCnt;
        logic [15:0] txDiv;
        logic [4:0] txByte;
        logic [7:0] txCur;
        logic [15:0] txSum;
        apf_pkg::apf_parse_t ps;
        logic [7:0] rxCnt;
        logic [15:0] rxSum;
        logic [7:0] rxCkHi;
        logic [apf_pkg::VEL_BYTES*8-1:0] rxPay;
        logic [apf_pkg::VEL_BYTES*8-1:0] velData;
        logic velStrobe;
        logic velAided;
        logic ckBad;
        logic [31:0] velTimer;
    } apf_main_t;

    apf_main_t st;
    apf_main_t next_st;
    logic tick;
    logic [7:0] rxByte;
    logic rxValid;
    logic rxErr;

    // Packet byte at a given index; checksum bytes use the running sum
    function automatic logic [7:0] pktByte(input apf_pkg::apf_frame_t f, input logic [4:0] idx,
                                           input logic [15:0] sum);
        logic [4:0] k;
        logic [7:0] b;
        k = idx - apf_pkg::IDX_PAY_FIRST;
        b = 8'h00;
        if (idx == 5'h00) begin
            b = apf_pkg::HDR0;
        end else if (idx == 5'h01) begin
            b = apf_pkg::HDR1;
        end else if (idx == apf_pkg::IDX_CK_HI) begin
            b = sum[15:8];
        end else if (idx == apf_pkg::IDX_CK_LO) begin
            b = sum[7:0];
        end else begin
            b = f[175 - 8*k -: 8];
        end
        return b;
    endfunction

    function automatic logic [31:0] periodFor(input logic [1:0] cfg);
        logic [31:0] p;
        case (cfg)
            2'h0: p = 32'(PERIOD0_CYC);
            2'h1: p = 32'(PERIOD1_CYC);
            2'h2: p = 32'(PERIOD2_CYC);
            default: p = 32'(PERIOD3_CYC);
        endcase
        return p;
    endfunction

    apf_uart_rx #(.BIT_CYC(VEL_BIT_CYC)) u_rx (
        .mclk(mclk),
        .rst(rst),
        .rxd(rxd),
        .rxData(rxByte),
        .rxValid(rxValid),
        .rxErr(rxErr)
    );

    assign tick = st.cfgTaken && (st.tickCnt == st.period - 32'h1);

    always_comb begin
        logic [4:0] nIdx;
        logic [7:0] nByte;
        nIdx = st.txByte + 5'h01;
        nByte = pktByte(st.txFrame, nIdx, st.txSum);
        next_st = st;
        next_st.sampleReq = 1'b0;
        next_st.velStrobe = 1'b0;
        next_st.ckBad = 1'b0;

        // ************************************************************
        // Output pacing
        // ************************************************************
        // Configuration strap is taken once after reset so the rate never drifts
        if (!st.cfgTaken) begin
            next_st.cfgTaken = 1'b1;
            next_st.period = periodFor(modelCfg);
            next_st.tickCnt = 32'h0;
        end else begin
            next_st.tickCnt = tick ? 32'h0 : st.tickCnt + 32'h1; // RQ5
        end

        // ************************************************************
        // Sample and process loop
        // ************************************************************
        case (st.cyc)
            apf_pkg::CY_SAMPLE: begin
                next_st.sampleReq = 1'b1; // RQ6
                next_st.cyc = apf_pkg::CY_PROCESS;
            end
            apf_pkg::CY_PROCESS: begin
                if (procDone) begin
                    // Heading is taken as given: magnetic, no declination
                    next_st.hold.meas = procData; // RQ9
                    next_st.hold.model = modelNum; // RQ4
                    next_st.hold.bitWord = bitWord; // RQ4
                    next_st.holdValid = 1'b1;
                    next_st.sampleReq = 1'b1; // RQ7
                end
            end
            default: begin
                next_st.cyc = apf_pkg::CY_SAMPLE;
            end
        endcase

        // ************************************************************
        // Serial transmit
        // ************************************************************
        // A result not yet sent when a newer one lands is overwritten
        if (tick && st.holdValid && !st.txBusy) begin
            next_st.txFrame = st.hold; // RQ8
            next_st.holdValid = procDone;
            next_st.txBusy = 1'b1;
            next_st.txShift = {1'b1, apf_pkg::HDR0, 1'b0}; // RQ1 RQ13
            next_st.txLine = 1'b0;
            next_st.txCur = apf_pkg::HDR0;
            next_st.txByte = 5'h00;
            next_st.txBitCnt = 4'h0;
            next_st.txDiv = 16'h0000;
            next_st.txSum = 16'h0000;
        end else if (st.txBusy) begin
            next_st.txDiv = st.txDiv + 16'h0001;
            if (st.txDiv == 16'(TX_BIT_CYC - 1)) begin
                next_st.txDiv = 16'h0000;
                next_st.txShift = {1'b1, st.txShift[9:1]};
                next_st.txLine = st.txShift[1];
                next_st.txBitCnt = st.txBitCnt + 4'h1;
                if (st.txBitCnt == apf_pkg::STOP_BIT) begin
                    next_st.txBitCnt = 4'h0;
                    if (st.txByte == apf_pkg::IDX_CK_LO) begin
                        next_st.txBusy = 1'b0;
                        next_st.txLine = 1'b1;
                    end else begin
                        next_st.txByte = nIdx;
                        next_st.txCur = nByte; // RQ12 RQ2
                        next_st.txShift = {1'b1, nByte, 1'b0}; // RQ13
                        next_st.txLine = 1'b0;
                        if (nIdx >= apf_pkg::IDX_PAY_FIRST && nIdx <= apf_pkg::IDX_PAY_LAST) begin
                            next_st.txSum = apf_pkg::csumAdd(st.txSum, nByte); // RQ3
                        end
                    end
                end
            end
        end

        // ************************************************************
        // Velocity packet receive
        // ************************************************************
        if (st.velTimer == 32'(VEL_TIMEOUT_CYC) - 32'h1) begin
            next_st.velAided = 1'b0; // RQ11
        end else begin
            next_st.velTimer = st.velTimer + 32'h1;
        end
        if (rxErr) begin
            next_st.ps = apf_pkg::PS_HDR0; // RQ15
        end else if (rxValid) begin
            case (st.ps)
                apf_pkg::PS_HDR0: begin
                    if (rxByte == apf_pkg::HDR0) begin
                        next_st.ps = apf_pkg::PS_HDR1; // RQ1
                    end
                end
                apf_pkg::PS_HDR1: begin
                    next_st.rxCnt = 8'h00;
                    next_st.rxSum = 16'h0000;
                    if (rxByte == apf_pkg::HDR1) begin
                        next_st.ps = apf_pkg::PS_BODY;
                    end else if (rxByte != apf_pkg::HDR0) begin
                        next_st.ps = apf_pkg::PS_HDR0; // RQ15
                    end
                end
                apf_pkg::PS_BODY: begin
                    next_st.rxPay = {st.rxPay[apf_pkg::VEL_BYTES*8-9:0], rxByte};
                    next_st.rxSum = apf_pkg::csumAdd(st.rxSum, rxByte); // RQ3
                    next_st.rxCnt = st.rxCnt + 8'h01;
                    if (st.rxCnt == apf_pkg::VEL_LAST) begin
                        next_st.ps = apf_pkg::PS_CK0;
                    end
                end
                apf_pkg::PS_CK0: begin
                    next_st.rxCkHi = rxByte;
                    next_st.ps = apf_pkg::PS_CK1;
                end
                apf_pkg::PS_CK1: begin
                    next_st.ps = apf_pkg::PS_HDR0;
                    if ({st.rxCkHi, rxByte} == st.rxSum) begin
                        next_st.velData = st.rxPay; // RQ10
                        next_st.velStrobe = 1'b1;
                        next_st.velAided = 1'b1;
                        next_st.velTimer = 32'h0;
                    end else begin
                        // A corrupt packet means the source is no longer trusted
                        next_st.velAided = 1'b0; // RQ15 RQ11
                        next_st.ckBad = 1'b1;
                    end
                end
                default: begin
                    next_st.ps = apf_pkg::PS_HDR0;
                end
            endcase
        end

        if (rst) begin
            next_st = '0;
            next_st.txLine = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign sampleReq = st.sampleReq;
    assign txd = st.txLine;
    assign velData = st.velData;
    assign velStrobe = st.velStrobe;
    assign velAided = st.velAided;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_first_header: assert property ($rose(st.txBusy) // RQ1
        |-> st.txCur == apf_pkg::HDR0 && !txd)
        else $error("first header byte or start bit wrong");
    chk_second_header: assert property (st.txBusy && st.txByte == 5'h01 // RQ1
        |-> st.txCur == apf_pkg::HDR1)
        else $error("second header byte wrong");
    chk_csum_tail: assert property (st.txBusy && st.txByte == apf_pkg::IDX_CK_HI // RQ2
        |-> st.txCur == st.txSum[15:8])
        else $error("checksum high byte wrong");
    chk_model_field: assert property (st.txBusy && st.txByte == apf_pkg::IDX_MODEL_HI // RQ4
        |-> st.txCur == st.txFrame.model[15:8])
        else $error("model number byte wrong");
    chk_heading_raw: assert property (st.txBusy && st.txByte == apf_pkg::IDX_HEADING_HI // RQ9
        |-> st.txCur == st.txFrame.meas.heading[15:8])
        else $error("heading byte altered");
    chk_tick_paced: assert property ($rose(st.txBusy) |-> $past(tick)) // RQ5
        else $error("packet started off the rate tick");
    chk_resample_done: assert property (procDone && st.cyc == apf_pkg::CY_PROCESS // RQ7
        |=> sampleReq)
        else $error("no new sample after processing");
    chk_idle_line: assert property (!st.txBusy && !$past(st.txBusy) |-> txd) // RQ13
        else $error("line not idle high");
    chk_stop_bit: assert property (st.txBusy && st.txBitCnt == apf_pkg::STOP_BIT |-> txd) // RQ13
        else $error("stop bit low");
    chk_bad_drop: assert property (st.ckBad |-> !velAided && !velStrobe) // RQ15
        else $error("bad velocity packet accepted");
    chk_vel_strobe: assert property (velStrobe |-> velAided ##1 !velStrobe) // RQ10
        else $error("velocity strobe not a single aided pulse");
    chk_timeout_fall: assert property (st.velTimer == 32'(VEL_TIMEOUT_CYC) - 32'h1 // RQ11
        && !(rxValid && st.ps == apf_pkg::PS_CK1) |=> !velAided)
        else $error("no fallback after velocity timeout");

    cov_packet_done: cover property ($fell(st.txBusy));
    cov_vel_good: cover property (velStrobe);
    cov_vel_bad: cover property (st.ckBad);
    cov_vel_lost: cover property ($fell(velAided));

endmodule
`default_nettype wire

// >>> apf_host_model.sv
// Host display receiver and velocity source facing the packet framer
`default_nettype none
module apf_host_model #(
    parameter int TX_BIT = int'(apf_pkg::TX_DIV),
    parameter int VEL_BIT = int'(apf_pkg::VEL_DIV)
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Host receiver
    // ****************************************************************
    logic [7:0] rxBytes[$];
    longint rxStart[$];
    int frameErrs;
    initial begin
        rxd = 1'b1;
        frameErrs = 0;
    end
    // Mid-bit sampling, so a baud error of a few cycles still decodes
    initial begin : hostRx
        logic [7:0] b;
        longint t;
        forever begin
            @(negedge txd);
            t = $time / 50;
            repeat (TX_BIT / 2) @(posedge mclk);
            if (txd !== 1'b0) frameErrs++;
            for (int i = 0; i < 8; i++) begin
                repeat (TX_BIT) @(posedge mclk);
                b[i] = txd;
            end
            repeat (TX_BIT) @(posedge mclk);
            if (txd !== 1'b1) frameErrs++;
            rxBytes.push_back(b);
            rxStart.push_back(t);
        end
    end
    // ****************************************************************
    // Velocity source
    // ****************************************************************
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            #2;
            rxd = frame[i];
            repeat (VEL_BIT - 1) @(posedge mclk);
        end
    endtask
    task automatic sendPacket(input logic [63:0] pay, input logic badCk);
        int sum;
        sum = 0;
        for (int i = 0; i < 8; i++) begin
            sum += pay[63-8*i -: 8];
        end
        sum = sum % 65535;
        if (badCk) begin
            sum = (sum + 1) % 65535;
        end
        sendByte(8'hAA);
        sendByte(8'h55);
        for (int i = 0; i < 8; i++) begin
            sendByte(pay[63-8*i -: 8]);
        end
        sendByte(8'(sum >> 8));
        sendByte(8'(sum));
    endtask
endmodule
`default_nettype wire

// >>> apf_framer_test.sv
// Self-checking bench for the attitude packet framer
`default_nettype none
module apf_framer_test;
    timeunit 1ns;
    timeprecision 100ps;
    // Short periods and bit times keep the run bearable; each period exceeds one packet
    localparam int P[4] = '{5000, 5500, 6000, 6500};
    localparam int VTO = 6000;
    localparam int TXB = 16;
    localparam int VELB = 40;
    logic mclk, rst, procDone, sampleReq, txd, rxd, velStrobe, velAided, autoProc;
    logic [1:0] modelCfg;
    logic [15:0] modelNum, bitWord;
    logic [63:0] velData;
    apf_pkg::apf_meas_t procData;
    int miscompares, checked;
    apf_framer #(.PERIOD0_CYC(P[0]), .PERIOD1_CYC(P[1]), .PERIOD2_CYC(P[2]),
        .PERIOD3_CYC(P[3]), .VEL_TIMEOUT_CYC(VTO), .TX_BIT_CYC(TXB), .VEL_BIT_CYC(VELB))
        dut (.mclk(mclk), .rst(rst),
        .modelCfg(modelCfg), .modelNum(modelNum), .bitWord(bitWord),
        .sampleReq(sampleReq), .procDone(procDone), .procData(procData), .txd(txd),
        .rxd(rxd), .velData(velData), .velStrobe(velStrobe), .velAided(velAided));
    apf_host_model #(.TX_BIT(TXB), .VEL_BIT(VELB)) host (.mclk(mclk), .txd(txd), .rxd(rxd));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic giveUp(input string msg);
        miscompares++;
        $display("[FAIL] %0t wait ran out: %s", $time, msg);
        end_of_test();
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic doReset(input logic [1:0] cfg, input int hold);
        rst = 1'b1;
        modelCfg = cfg;
        step(hold);
        // A byte cut short by reset has been taken in by now, so nothing stale is queued
        host.rxBytes.delete();
        host.rxStart.delete();
        host.frameErrs = 0;
        rst = 1'b0;
    endtask
    task automatic waitBytes(input int n, input int bound);
        for (int k = 0; host.rxBytes.size() < n; k++) begin
            if (k == bound) giveUp("packet bytes");
            step(1000);
        end
    endtask
    // Stands in for the processing stage once the loop test is over
    always @(negedge mclk) begin
        if (autoProc && sampleReq === 1'b1) begin
            step(5);
            procDone = 1'b1;
            step(1);
            procDone = 1'b0;
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic testLoop();
        int k;
        doReset(2'h0, 20);
        for (k = 0; k < 10 && sampleReq !== 1'b1; k++) step(1);
        if (k == 10) giveUp("first sample request");
        for (int d = 1; d < 8; d += 3) begin
            for (k = 0; k < d; k++) begin
                step(1);
                check(sampleReq, 0, "sample request idle");
            end
            procDone = 1'b1;
            step(1);
            procDone = 1'b0;
            check(sampleReq, 1, "sample after processing");
        end
    endtask
    task automatic testPacket();
        logic [175:0] flat;
        logic [7:0] exp[26];
        int sum;
        autoProc = 1'b1;
        flat = {procData, modelNum, bitWord};
        sum = 0;
        exp[0] = 8'hAA;
        exp[1] = 8'h55;
        for (int i = 0; i < 22; i++) begin
            exp[i+2] = flat[175-8*i -: 8];
            sum += exp[i+2];
        end
        sum = sum % 65535;
        exp[24] = 8'(sum >> 8);
        exp[25] = 8'(sum);
        waitBytes(52, 20);
        for (int i = 0; i < 26; i++) begin
            check(host.rxBytes[i], exp[i], "packet byte");
        end
        check({host.rxBytes[6], host.rxBytes[7]}, procData.heading, "heading");
        check(host.rxBytes[26], 8'hAA, "second packet");
    endtask
    task automatic testVelocity();
        logic [63:0] pay[2];
        int n;
        pay = '{64'hFFFE_8001_7F00_C355, 64'h7FFF_0001_8000_FFFF};
        // Good packet, bad packet before the timeout, then good again and let it time out
        for (int r = 0; r < 2; r++) begin
            fork
                host.sendPacket(pay[r], 1'b0);
                begin
                    for (n = 0; n < 6000 && velStrobe !== 1'b1; n++) step(1);
                    if (n == 6000) giveUp("velocity strobe");
                    check(velData, pay[r], "velocity fields");
                    check(velAided, 1, "aided mode");
                    if (r == 1) begin
                        for (n = 0; velAided === 1'b1 && n < VTO + 100; n++) step(1);
                        check(64'(n >= VTO - 3 && n <= VTO + 3), 1, "aided timeout");
                    end
                end
            join
            if (r == 0) begin
                n = 0;
                fork
                    host.sendPacket(64'h1122_3344_5566_7788, 1'b1);
                    repeat (5200) begin
                        step(1);
                        if (velStrobe === 1'b1) n++;
                    end
                join
                step(5);
                check(n, 0, "bad checksum strobe");
                check(velData, pay[0], "bad checksum data kept");
                check(velAided, 0, "bad checksum unaided");
            end
        end
    endtask
    task automatic testRates();
        for (int c = 0; c < 4; c++) begin
            check(host.frameErrs, 0, "serial framing");
            doReset(2'(c), 200);
            waitBytes(27, 2 * P[c] / 1000 + 5);
            check(64'(host.rxStart[26] - host.rxStart[0]), 64'(P[c]), "rate");
        end
        check(host.frameErrs, 0, "serial framing");
    endtask
    initial begin
        rst = 1'b1;
        modelCfg = 2'h0;
        procDone = 1'b0;
        autoProc = 1'b0;
        modelNum = 16'h00D6;
        bitWord = 16'h8081;
        procData = {16'hFF9C, 16'h0123, 16'hC000, 16'h7FFF, 16'h8000,
            16'h00FF, 16'hFE01, 16'h1234, 16'hF00D};
        miscompares = 0;
        checked = 0;
        testLoop();
        testPacket();
        testVelocity();
        testRates();
        end_of_test();
    end
endmodule
`default_nettype wire
